// *** usmo_pkg.sv ***
// Summary of operation
// - spi clock idles at polarity bit level
// - nine-bit bit forces 9-bit characters
// - drive clock pin unless external clock
// - sample at 16x, or 8x when set
// - nack inhibit suppresses nack generation
// - inhibit makes spi master wait receive-empty
// - without limit, nack every parity error
// - with limit, count errors, stop, flag
// - inversion flips transmitted and received data
// - variable sync takes sync per written character
// - repeat maximum bounds t0 repetitions
// - filter takes two-of-three majority vote
// - biphase enable turns codec on or off
// - start bit edge follows msync bit 30
// - delimiter is sync pattern or one bit
// - enable-set write ones enable sources
// - enable-clear write ones disable sources
// - view register reads enabled sources
// - shared bit layout across three registers
// - bits 10 and 13 shared by mode
// - underrun only in spi slave, sticky
package usmo_pkg;
	localparam logic [31:0] ADDR_MODE = 32'h40098004;
	localparam logic [31:0] ADDR_IEN_SET = 32'h40098008;
	localparam logic [31:0] ADDR_IEN_CLR = 32'h4009800c;
	localparam logic [31:0] ADDR_IEN_VIEW = 32'h40098010;
	localparam logic [31:0] ADDR_STATUS = 32'h40098014;
	localparam logic [31:0] ADDR_CMD = 32'h40098000;
	localparam logic [31:0] ADDR_RXHOLD = 32'h40098018;
	localparam logic [31:0] ADDR_TXHOLD = 32'h4009801c;
	// implemented source bits: 0..15, 19, 24..29
	localparam logic [31:0] IRQ_VALID = 32'h3f08ffff;
	localparam logic [31:0] MODE_RESET = 32'h00000000;
	localparam logic [31:0] IEN_RESET = 32'h00000000;
	// only the transmit-ready flag is up after reset
	localparam logic [31:0] STATUS_RESET = 32'h00000002;
	// flags cleared by the status-reset command; bit 13 is handled per mode
	localparam logic [31:0] RSTSTA_MASK = 32'h3f00c4e4;
	localparam logic [3:0] MODE_T0 = 4'h4;
	localparam logic [3:0] MODE_SPI_MASTER = 4'he;
	localparam logic [3:0] MODE_SPI_SLAVE = 4'hf;
	localparam logic [3:0] MODE_LIN_MASTER = 4'ha;
	localparam logic [3:0] MODE_LIN_SLAVE = 4'hb;
	localparam logic [1:0] CLKSRC_EXT = 2'h3;
	localparam int B_CPOL = 16;
	localparam int B_NINE = 17;
	localparam int B_SERIAL_CLOCK_DRIVE = 18;
	localparam int B_OVER = 19;
	localparam int B_NACK_INHIBIT = 20;
	localparam int B_SUCCESSIVE_NACK_LIMIT = 21;
	localparam int B_VSYNC = 22;
	localparam int B_INV = 23;
	localparam int B_FILTER = 28;
	localparam int B_MAN = 29;
	localparam int B_MSYNC = 30;
	localparam int B_SINGLE_BIT_DELIMITER = 31;
	localparam int S_RECEIVE_READY_FLAG = 0;
	localparam int S_TRANSMIT_READY_FLAG = 1;
	localparam int S_PARE = 7;
	localparam int S_REPEAT_REACHED_SOURCE = 10;
	localparam int S_NACK = 13;
	localparam int C_RSTSTA = 8;
	localparam int C_RSTIT = 10;
	localparam int C_RSTNACK = 14;
	localparam logic [3:0] OVS_16 = 4'hf;
	localparam logic [3:0] OVS_8 = 4'h7;
endpackage

// *** usmo_core.sv ***
module usmo_core
	import usmo_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// raw status events from the serial engines
	input wire logic [31:0] eventIn,
	input wire logic parityErrEvent,
	input wire logic underrunEvent,
	input wire logic spiBusy,
	input wire logic spiClkPhase,
	input wire logic [8:0] rxLineChar,
	input wire logic rxLineValid,
	input wire logic rxLineSync,
	input wire logic rxLineRaw,
	input wire logic txShiftTake,
	output logic spiSerialClock,
	output logic serialClockOut,
	output logic serialClockOe,
	output logic [3:0] charBits,
	output logic [3:0] sampleLast,
	output logic nackSend,
	output logic txStart,
	output logic [8:0] txChar,
	output logic txCharValid,
	output logic txSyncCmd,
	output logic rxFiltered,
	output logic biphaseEncEnable,
	output logic biphaseDecEnable,
	output logic startEdgeFalling,
	output logic singleBitDelimiter,
	output logic irq
);
	////////////////////////////////////////////////////////////
	logic [31:0] modeReg;
	logic [31:0] ienMask;
	logic [31:0] status;
	logic [8:0] rxHold;
	logic rxHoldSync;
	logic [8:0] txHold;
	logic txHoldSync;
	logic [7:0] repeatCount;
	logic [2:0] rxSamples;
	logic [3:0] ovsCount;
	logic wrMode, wrSet, wrClr, wrCmd, wrTx, rdRx, rdStatus;
	logic [3:0] opMode;
	logic [2:0] repeatMax;
	logic [31:0] next_status;
	logic linMode;

	assign opMode = modeReg[3:0];
	assign repeatMax = modeReg[26:24];
	assign linMode = opMode == MODE_LIN_MASTER || opMode == MODE_LIN_SLAVE;
	assign wrMode = regWr && regAddr == ADDR_MODE;
	assign wrSet = regWr && regAddr == ADDR_IEN_SET;
	assign wrClr = regWr && regAddr == ADDR_IEN_CLR;
	assign wrCmd = regWr && regAddr == ADDR_CMD;
	assign wrTx = regWr && regAddr == ADDR_TXHOLD;
	assign rdRx = regRd && regAddr == ADDR_RXHOLD;
	assign rdStatus = regRd && regAddr == ADDR_STATUS;

	////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			modeReg <= MODE_RESET;
		else if (wrMode)
			modeReg <= regWdata;
	end

	// set wins when one write carries both (cannot happen: separate registers)
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ienMask <= IEN_RESET;
		else if (wrSet)
			ienMask <= (ienMask | regWdata) & IRQ_VALID;
		else if (wrClr)
			ienMask <= ienMask & ~regWdata;
	end

	////////////////////////////////////////////////////////////
	// nack inhibit
	logic nackAllowed;
	logic limitReached;
	assign nackAllowed = !modeReg[B_NACK_INHIBIT];
	assign limitReached = repeatCount >= {5'h00, repeatMax};

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			nackSend <= 1'b0;
		else if (!modeReg[B_SUCCESSIVE_NACK_LIMIT])
			nackSend <= parityErrEvent && nackAllowed;
		else
			nackSend <= parityErrEvent && nackAllowed && !limitReached;
	end

	// consecutive errors; a clean character restarts the count
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			repeatCount <= 8'h00;
		else if (wrCmd && regWdata[C_RSTIT])
			repeatCount <= 8'h00;
		else if (parityErrEvent && !limitReached)
			repeatCount <= repeatCount + 8'h01;
		else if (rxLineValid && !parityErrEvent)
			repeatCount <= 8'h00;
	end

	////////////////////////////////////////////////////////////
	// sticky flags: hardware set wins over software clear
	always_comb begin
		next_status = status;
		if (wrCmd && regWdata[C_RSTSTA])
			next_status = next_status & ~RSTSTA_MASK;
		// bit 13 is break flag in lin modes, nack otherwise
		if (wrCmd && regWdata[C_RSTSTA] && linMode)
			next_status[S_NACK] = 1'b0;
		if (wrCmd && regWdata[C_RSTNACK] && !linMode)
			next_status[S_NACK] = 1'b0;
		if (wrCmd && regWdata[C_RSTIT] && opMode == MODE_T0)
			next_status[S_REPEAT_REACHED_SOURCE] = 1'b0;
		if (rdRx)
			next_status[S_RECEIVE_READY_FLAG] = 1'b0;
		if (rdStatus)
			next_status[19] = 1'b0;
		next_status = next_status | (eventIn & IRQ_VALID & ~32'h00000403);
		next_status[S_PARE] = next_status[S_PARE] | parityErrEvent;
		if (opMode == MODE_SPI_SLAVE)
			next_status[S_REPEAT_REACHED_SOURCE] = next_status[S_REPEAT_REACHED_SOURCE] | underrunEvent;
		else if (modeReg[B_SUCCESSIVE_NACK_LIMIT])
			next_status[S_REPEAT_REACHED_SOURCE] = next_status[S_REPEAT_REACHED_SOURCE] | (parityErrEvent && limitReached);
		if (rxLineValid)
			next_status[S_RECEIVE_READY_FLAG] = 1'b1;
		next_status[S_TRANSMIT_READY_FLAG] = !txCharValid;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			status <= STATUS_RESET;
		else
			status <= next_status;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(next_status & ienMask);
	end

	////////////////////////////////////////////////////////////
	// receive inversion
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rxHold <= 9'h000;
			rxHoldSync <= 1'b0;
		end else if (rxLineValid) begin
			rxHold <= modeReg[B_INV] ? ~rxLineChar : rxLineChar;
			rxHoldSync <= rxLineSync;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			txHold <= 9'h000;
			txHoldSync <= 1'b0;
			txCharValid <= 1'b0;
		end else if (wrTx) begin
			txHold <= regWdata[8:0];
			txHoldSync <= modeReg[B_VSYNC] ? regWdata[15] : modeReg[B_MSYNC];
			txCharValid <= 1'b1;
		end else if (txShiftTake)
			txCharValid <= 1'b0;
	end

	assign txChar = modeReg[B_INV] ? ~txHold : txHold;
	assign txSyncCmd = txHoldSync;

	assign txStart = txCharValid && opMode == MODE_SPI_MASTER &&
		(!modeReg[B_NACK_INHIBIT] || !status[S_RECEIVE_READY_FLAG]);

	////////////////////////////////////////////////////////////
	// nine-bit override
	assign charBits = modeReg[B_NINE] ? 4'h9 : 4'h5 + {2'b00, modeReg[7:6]};
	assign sampleLast = modeReg[B_OVER] ? OVS_8 : OVS_16;

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ovsCount <= 4'h0;
		else if (ovsCount >= sampleLast)
			ovsCount <= 4'h0;
		else
			ovsCount <= ovsCount + 4'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			rxSamples <= 3'b111;
		else if (ovsCount == 4'h0)
			rxSamples <= {rxSamples[1:0], rxLineRaw};
	end

	assign rxFiltered = modeReg[B_FILTER] ?
		(rxSamples[0] & rxSamples[1]) | (rxSamples[1] & rxSamples[2]) | (rxSamples[0] & rxSamples[2]) :
		rxLineRaw;

	////////////////////////////////////////////////////////////
	// idle polarity
	assign spiSerialClock = (opMode == MODE_SPI_MASTER || opMode == MODE_SPI_SLAVE) && spiBusy ?
		modeReg[B_CPOL] ^ spiClkPhase : modeReg[B_CPOL];
	assign serialClockOut = spiSerialClock;
	assign serialClockOe = modeReg[B_SERIAL_CLOCK_DRIVE] && modeReg[5:4] != CLKSRC_EXT;
	assign biphaseEncEnable = modeReg[B_MAN];
	assign biphaseDecEnable = modeReg[B_MAN];
	assign startEdgeFalling = modeReg[B_MSYNC];
	assign singleBitDelimiter = modeReg[B_SINGLE_BIT_DELIMITER];

	////////////////////////////////////////////////////////////
	// view enabled set
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			regRdata <= 32'h00000000;
		else if (!regRd)
			regRdata <= 32'h00000000;
		else if (regAddr == ADDR_IEN_VIEW)
			regRdata <= ienMask;
		else if (regAddr == ADDR_MODE)
			regRdata <= modeReg;
		else if (regAddr == ADDR_STATUS)
			regRdata <= status;
		else if (regAddr == ADDR_RXHOLD)
			regRdata <= {16'h0000, rxHoldSync, 6'h00, rxHold};
		else
			regRdata <= 32'h00000000;
	end
endmodule

// *** usmo_monitor.sv ***
module usmo_monitor
	import usmo_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic parityErrEvent,
	input wire logic spiBusy,
	input wire logic spiSerialClock,
	input wire logic serialClockOe,
	input wire logic [3:0] charBits,
	input wire logic [3:0] sampleLast,
	input wire logic nackSend,
	input wire logic biphaseEncEnable,
	input wire logic biphaseDecEnable,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] ienSh;
	logic [31:0] modeSh;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// shadow copies, so outputs can be tied to what software wrote
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ienSh <= IEN_RESET;
			modeSh <= MODE_RESET;
		end else if (regWr && regAddr == ADDR_MODE)
			modeSh <= regWdata;
		else if (regWr && regAddr == ADDR_IEN_SET)
			ienSh <= ienSh | (regWdata & IRQ_VALID);
		else if (regWr && regAddr == ADDR_IEN_CLR)
			ienSh <= ienSh & ~regWdata;
	end
	chk_view_value: assert property (
		$past(regRd && regAddr == ADDR_IEN_VIEW) |-> regRdata == $past(ienSh)) else $error("view mismatch");
	chk_char_bits: assert property (
		charBits == (modeSh[B_NINE] ? 4'h9 : 4'h5 + 4'(modeSh[7:6]))) else $error("char length");
	chk_sample_rate: assert property (
		sampleLast == (modeSh[B_OVER] ? OVS_8 : OVS_16)) else $error("sample rate");
	chk_clock_drive: assert property (
		serialClockOe == (modeSh[B_SERIAL_CLOCK_DRIVE] && modeSh[5:4] != CLKSRC_EXT)) else $error("clock drive");
	chk_codec_pair: assert property (
		biphaseEncEnable == modeSh[B_MAN] && biphaseDecEnable == modeSh[B_MAN]) else $error("codec enable");
	chk_spi_idle: assert property (
		modeSh[3:1] == 3'h7 && !spiBusy |-> spiSerialClock == modeSh[B_CPOL]) else $error("clock idle");
	chk_nack_inhibit: assert property (
		$past(modeSh[B_NACK_INHIBIT]) |-> !nackSend) else $error("nack inhibit");
	chk_nack_prompt: assert property (
		parityErrEvent && modeSh[3:0] == MODE_T0 && !modeSh[B_NACK_INHIBIT] && !modeSh[B_SUCCESSIVE_NACK_LIMIT] |=> nackSend)
		else $error("nack missing");
	cover property (nackSend);
	cover property (irq);
	cover property (regRd && regAddr == ADDR_IEN_VIEW);
endmodule
////////////////////////////////////////////////////////////
bind usmo_core usmo_monitor usmo_monitor_i (.*);

// *** usmo_peer.sv ***
module usmo_peer (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic txCharValid,
	input wire logic [8:0] txChar,
	input wire logic sendReq,
	input wire logic [8:0] sendChar,
	input wire logic sendBad,
	output logic txShiftTake,
	output logic [8:0] rxLineChar,
	output logic rxLineValid,
	output logic parityErrEvent,
	output logic [8:0] lastTx
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge sys_clk) begin
		txShiftTake <= !sys_rst && txCharValid && !txShiftTake;
		if (txCharValid && !txShiftTake)
			lastTx <= txChar;
	end
	// char bus means nothing without valid, so it churns in between
	always_ff @(posedge sys_clk) begin
		rxLineValid <= !sys_rst && sendReq;
		parityErrEvent <= !sys_rst && sendReq && sendBad;
		rxLineChar <= sys_rst ? 9'h0 : sendReq ? sendChar : ~rxLineChar;
	end
endmodule

// *** usmo_core_bench.sv ***
module usmo_core_bench;
	import usmo_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, sendReq = 1'b0, sendBad = 1'b0;
	logic [31:0] regAddr = 32'h0, regWdata = 32'h0, eventIn = 32'h0, regRdata, got;
	logic [8:0] sendChar = 9'h0, txChar, rxLineChar, lastTx;
	logic [3:0] charBits, sampleLast;
	logic spiSerialClock, serialClockOe, nackSend, biphaseEncEnable, biphaseDecEnable, startEdgeFalling;
	logic singleBitDelimiter, irq, txShiftTake, rxLineValid, parityErrEvent, txCharValid;
	logic underrunEvent = 1'b0, rxLineRaw = 1'b1, serialClockOut, txStart, txSyncCmd, rxFiltered;
	int mismatches = 0, compares = 0, nacks = 0;
	// mode word, then expected {bits, last, 0, pin, oe, enc, dec, fall, single_bit_delimiter, clock}
	logic [47:0] rows [4] = '{48'h0000000e_5f00, 48'h000f00ce_9761, 48'he00400bf_7f1e, 48'h0004005e_6f20};
	usmo_core usmo_core_i (.*, .spiBusy(1'b0), .spiClkPhase(1'b0), .rxLineSync(1'b0));
	usmo_peer usmo_peer_i (.*);
	initial forever #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (nackSend === 1'b1) nacks++;
	task check(input string name, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		#1;
	endtask
	task rd(input logic [31:0] a);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 got = regRdata;
	endtask
	task send(input logic [8:0] c, input logic bad);
		sendChar <= c;
		sendBad <= bad;
		sendReq <= 1'b1;
		idle(1);
		sendReq <= 1'b0;
		idle(3);
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		rd(ADDR_IEN_VIEW);
		check("view reset", IEN_RESET, got);
		$display("reset done");
		foreach (rows[i]) begin
			wr(ADDR_MODE, rows[i][47:16]);
			check("config", {16'h0, rows[i][15:0]}, {16'h0, charBits, sampleLast, 1'b0, serialClockOut, serialClockOe,
				biphaseEncEnable, biphaseDecEnable, startEdgeFalling, singleBitDelimiter, spiSerialClock});
		end
		$display("config done");
		wr(ADDR_IEN_SET, 32'hffffffff);
		rd(ADDR_IEN_VIEW);
		check("view set", IRQ_VALID, got);
		wr(ADDR_IEN_CLR, 32'h00000401);
		wr(ADDR_IEN_SET, 32'h00000001);
		rd(ADDR_IEN_VIEW);
		check("view clear", 32'h3f08fbff, got);
		rd(32'h40098020);
		check("unmapped", 32'h0, got);
		$display("mask done");
		wr(ADDR_IEN_CLR, 32'hffffffff);
		wr(ADDR_IEN_SET, 32'h00000020);
		eventIn <= 32'h00000020;
		idle(1);
		eventIn <= 32'h0;
		idle(3);
		check("irq raised", 32'h1, {31'h0, irq});
		wr(ADDR_CMD, 32'h00000100);
		idle(3);
		check("irq cleared", 32'h0, {31'h0, irq});
		$display("irq done");
		wr(ADDR_MODE, 32'h00000004);
		send(9'h011, 1'b1);
		wr(ADDR_MODE, 32'h02200004);
		send(9'h012, 1'b0);
		repeat (3) send(9'h013, 1'b1);
		rd(ADDR_STATUS);
		check("repeat flag", 32'h400, got & 32'h400);
		wr(ADDR_MODE, 32'h00100004);
		send(9'h014, 1'b1);
		check("nack count", 32'h3, 32'(nacks));
		$display("nack done");
		wr(ADDR_MODE, 32'h008000c0);
		wr(ADDR_TXHOLD, 32'h000000a5);
		idle(4);
		check("tx data", 32'h5a, {24'h0, lastTx[7:0]});
		send(9'h05a, 1'b0);
		rd(ADDR_RXHOLD);
		check("rx data", 32'ha5, got & 32'hff);
		$display("inversion done");
		// receive-ready still up from this character holds the start
		wr(ADDR_MODE, 32'h0050000e);
		send(9'h033, 1'b0);
		wr(ADDR_TXHOLD, 32'h000080a5);
		check("start held", 32'h0, {31'h0, txStart});
		check("sync variable", 32'h1, {31'h0, txSyncCmd});
		rd(ADDR_RXHOLD);
		wr(ADDR_MODE, 32'h4010000e);
		wr(ADDR_TXHOLD, 32'h000000a6);
		check("start free", 32'h1, {31'h0, txStart});
		check("sync fixed", 32'h1, {31'h0, txSyncCmd});
		send(9'h034, 1'b0);
		wr(ADDR_MODE, 32'h0000000e);
		wr(ADDR_TXHOLD, 32'h00000007);
		check("start plain", 32'h1, {31'h0, txStart});
		check("sync data", 32'h0, {31'h0, txSyncCmd});
		$display("spi start done");
		wr(ADDR_CMD, 32'h00000100);
		underrunEvent <= 1'b1;
		idle(1);
		underrunEvent <= 1'b0;
		rd(ADDR_STATUS);
		check("underrun master", 32'h0, got & 32'h400);
		wr(ADDR_MODE, 32'h0000000f);
		underrunEvent <= 1'b1;
		idle(1);
		underrunEvent <= 1'b0;
		idle(4);
		rd(ADDR_STATUS);
		check("underrun slave", 32'h400, got & 32'h400);
		wr(ADDR_CMD, 32'h00000100);
		rd(ADDR_STATUS);
		check("underrun cleared", 32'h0, got & 32'h400);
		$display("underrun done");
		wr(ADDR_MODE, 32'h10000000);
		rxLineRaw <= 1'b0;
		idle(1);
		check("filter glitch", 32'h1, {31'h0, rxFiltered});
		idle(63);
		check("filter low", 32'h0, {31'h0, rxFiltered});
		wr(ADDR_MODE, 32'h00000000);
		rxLineRaw <= 1'b1;
		idle(1);
		check("filter off", 32'h1, {31'h0, rxFiltered});
		$display("filter done");
		wr(ADDR_IEN_SET, 32'h00000002);
		idle(1);
		check("irq ready", 32'h1, {31'h0, irq});
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		rd(ADDR_IEN_VIEW);
		check("view rerun", IEN_RESET, got);
		check("irq rerun", 32'h0, {31'h0, irq});
		rd(ADDR_STATUS);
		check("status rerun", STATUS_RESET, got);
		$display("second reset done");
		stop_test;
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		mismatches++;
		stop_test;
	end
endmodule
